/* rtl/lmc_consts.svh */
`ifndef LMC_CONSTS_SVH
`define LMC_CONSTS_SVH

// Transceiver mode field codes
`define LMC_MODE_OFF 2'h0
`define LMC_MODE_WAKE 2'h1
`define LMC_MODE_RXONLY 2'h2
`define LMC_MODE_NORMAL 2'h3

// System mode codes
`define LMC_SYS_NORMAL 3'h0
`define LMC_SYS_STOP 3'h1
`define LMC_SYS_SLEEP 3'h2
`define LMC_SYS_RESTART 3'h3
`define LMC_SYS_FAILSAFE 3'h4

// Slope codes driven to the analog stage
`define LMC_SLOPE_NORMAL 2'h0
`define LMC_SLOPE_LOW 2'h1
`define LMC_SLOPE_FLASH 2'h2

// Timing in microseconds and the clock rate in MHz
`define LMC_CLK_MHZ 20
`define LMC_EN_TIME_US 10
`define LMC_WAKE_FILT_US 150
`define LMC_TXD_TO_US 2000
`define LMC_BUS_TO_US 2000

// Cycle counts: each time in microseconds times the clock rate in MHz
`define LMC_EN_CYC (`LMC_EN_TIME_US * `LMC_CLK_MHZ)
`define LMC_WAKE_CYC (`LMC_WAKE_FILT_US * `LMC_CLK_MHZ)
`define LMC_TXD_TO_CYC (`LMC_TXD_TO_US * `LMC_CLK_MHZ)
`define LMC_BUS_TO_CYC (`LMC_BUS_TO_US * `LMC_CLK_MHZ)

`define LMC_CNT_W 16

`endif

/* rtl/lmc_pkg.sv */
package lmc_pkg;

    typedef enum logic [1:0] {
        LMC_OFF = 2'h0,
        LMC_WAKE = 2'h1,
        LMC_RXONLY = 2'h2,
        LMC_NORMAL = 2'h3
    } lmc_mode_t;

    typedef enum logic [2:0] {
        LMC_SYS_NRM = 3'h0,
        LMC_SYS_STP = 3'h1,
        LMC_SYS_SLP = 3'h2,
        LMC_SYS_RST = 3'h3,
        LMC_SYS_FS = 3'h4
    } lmc_sys_t;

    // Events toward the system controller
    typedef struct packed {
        logic irq;
        logic to_restart;
        logic wdog_enable;
    } lmc_sys_req_t;

    // Serial write of the transceiver control fields
    typedef struct packed {
        logic wr;
        logic [1:0] mode;
        logic low_slope;
        logic flash;
    } lmc_cfg_t;

endpackage

/* rtl/lmc_mode_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
`include "lmc_consts.svh"

// Functional notes
// - Mode field written over serial port selects off, normal, receive-only or wake.
// - After reset mode is off, all transmit and receive halted.
// - Off mode ignores bus wake and never signals it.
// - Normal mode accepted only in system normal or stop mode.
// - After enable time only a fresh dominant edge is transmitted.
// - Receive-only disables driver, keeps receive; only in system normal or stop.
// - Wake mode allowed in stop, sleep, restart, normal; forced in fail-safe.
// - Bus dominant beyond wake filter pulls receive low until mode change.
// - Mode field keeps reading wake code after a wake.
// - Leaving wake mode and returning rearms wake detection.
// - System entering stop, sleep or fail-safe rearms wake detection.
// - Wake in stop or normal raises interrupt, status flag, receive low.
// - Wake in stop with option set re-enables the watchdog.
// - Wake in sleep requests restart then normal, no interrupt.
// - Long transmit dominant disables driver, sets fault, recovers when released.
// - Long bus dominant in any mode sets the fault flag.
// - Bus supply under-voltage disables driver and receiver, mode kept.
// - Default slope normal; low-slope bit selects slower slope only.
// - Low-slope takes effect on select release; changeable in system normal only.
// - Flash bit in system normal disables slope control on select release.
module lmc_mode_ctrl
    import lmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire lmc_cfg_t cfg_in,
    input wire logic serial_select_n,
    input wire logic [2:0] sys_mode,
    input wire logic watchdog_on_bus_wake,
    input wire logic watchdog_disabled,
    input wire logic lin_transmit_input,
    input wire logic bus_rx_level,
    input wire logic bus_supply_under_v,
    input wire logic fault_clear,
    input wire logic wake_status_clear,
    output logic [1:0] lin_mode_field,
    output logic bus_drive_dominant,
    output logic driver_enable,
    output logic receiver_enable,
    output logic rx_out,
    output logic [1:0] slope_sel,
    output logic lin_fault_flag,
    output logic wake_status_first,
    output lmc_sys_req_t sys_req
);

    // Pin synchronisers; first stage read only by the second
    // Reset to the idle pin levels so no false edge follows reset
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pin_s1_q <= 4'he;
            pin_s2_q <= 4'he;
        end else begin
            pin_s1_q <= {lin_transmit_input, bus_rx_level, serial_select_n,
                         bus_supply_under_v};
            pin_s2_q <= pin_s1_q;
        end
    end

    wire txd_s = pin_s2_q[3];
    wire bus_s = pin_s2_q[2];
    wire csn_s = pin_s2_q[1];
    wire uv_s = pin_s2_q[0];

    // Control state
    logic [1:0] mode_q;
    logic [2:0] sys_q;
    logic csn_q;
    logic txd_q;
    logic wake_armed_q;
    logic woken_q;
    logic enabled_q;
    logic tx_gate_q;
    logic txd_to_q;
    logic ls_pend_q;
    logic fl_pend_q;
    logic [`LMC_CNT_W-1:0] en_cnt_q;
    logic [`LMC_CNT_W-1:0] wk_cnt_q;
    logic [`LMC_CNT_W-1:0] tx_cnt_q;
    logic [`LMC_CNT_W-1:0] bs_cnt_q;

    // System mode decoding
    function automatic logic sys_is(input logic [2:0] s, input logic [2:0] code);
        sys_is = (s == code);
    endfunction

    wire sys_nrm = sys_is(sys_mode, `LMC_SYS_NORMAL);
    wire sys_stp = sys_is(sys_mode, `LMC_SYS_STOP);
    wire sys_slp = sys_is(sys_mode, `LMC_SYS_SLEEP);
    wire sys_rst = sys_is(sys_mode, `LMC_SYS_RESTART);
    wire sys_fs = sys_is(sys_mode, `LMC_SYS_FAILSAFE);
    wire sys_chg = (sys_mode != sys_q);

    // Mode request legality per system mode
    wire req_ok = (cfg_in.mode == `LMC_MODE_OFF) ? 1'b1 :
        (cfg_in.mode == `LMC_MODE_NORMAL) ? (sys_nrm | sys_stp) :
        (cfg_in.mode == `LMC_MODE_RXONLY) ? (sys_nrm | sys_stp) :
        (sys_stp | sys_slp | sys_rst | sys_nrm);
    wire wr_mode = cfg_in.wr & req_ok & ~sys_fs;
    wire [1:0] mode_d = sys_fs ? `LMC_MODE_WAKE :
        (wr_mode ? cfg_in.mode : mode_q);
    wire mode_chg = (mode_d != mode_q);

    wire in_wake = (mode_q == `LMC_MODE_WAKE);
    wire in_norm = (mode_q == `LMC_MODE_NORMAL);
    wire in_rxo = (mode_q == `LMC_MODE_RXONLY);

    // Rearm on mode toggle or entry to a low-power system mode
    wire rearm = mode_chg |
        (sys_chg & (sys_stp | sys_slp | sys_fs));

    // Wake filter: counts bus dominant in wake mode, armed or not; hits only when armed
    wire wake_hit = in_wake & wake_armed_q & ~bus_s & ~uv_s &
        (wk_cnt_q == `LMC_CNT_W'(`LMC_WAKE_CYC));

    // Terminal counts and edges
    wire en_done = (en_cnt_q == `LMC_CNT_W'(`LMC_EN_CYC));
    wire txd_fall = txd_q & ~txd_s;
    wire tx_hit = ~txd_s & (tx_cnt_q == `LMC_CNT_W'(`LMC_TXD_TO_CYC));
    wire bus_hit = ~bus_s & (bs_cnt_q == `LMC_CNT_W'(`LMC_BUS_TO_CYC));

    // Driver path: gate opens on first fresh dominant after enable
    wire drv_allow = in_norm & enabled_q & ~uv_s & ~txd_to_q;
    wire csn_rise = ~csn_q & csn_s;

    // Mode and tracking registers
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            mode_q <= `LMC_MODE_OFF;
            sys_q <= `LMC_SYS_NORMAL;
            csn_q <= 1'b1;
            txd_q <= 1'b1;
        end else begin
            mode_q <= mode_d;
            sys_q <= sys_mode;
            csn_q <= csn_s;
            txd_q <= txd_s;
        end
    end

    // Wake arming and wake latch
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wake_armed_q <= 1'b1;
            woken_q <= 1'b0;
        end else if (rearm) begin
            wake_armed_q <= 1'b1;
            // A system rearm keeps receive low; only a mode change releases it
            woken_q <= woken_q & ~mode_chg;
        end else if (wake_hit) begin
            wake_armed_q <= 1'b0;
            woken_q <= 1'b1;
        end
    end

    // Wake filter counter, restarts on any recessive
    always_ff @(posedge core_clk) begin
        if (!resetn || bus_s || !in_wake || rearm)
            wk_cnt_q <= '0;
        else if (!wake_hit)
            wk_cnt_q <= wk_cnt_q + 1'b1;
    end

    // Enable time counter from entry to normal mode
    always_ff @(posedge core_clk) begin
        if (!resetn || !in_norm || mode_chg) begin
            en_cnt_q <= '0;
            enabled_q <= 1'b0;
        end else if (!en_done) begin
            en_cnt_q <= en_cnt_q + 1'b1;
        end else begin
            enabled_q <= 1'b1;
        end
    end

    // Only a dominant that starts after enable is forwarded
    always_ff @(posedge core_clk) begin
        if (!resetn || !enabled_q)
            tx_gate_q <= 1'b0;
        else if (txd_fall)
            tx_gate_q <= 1'b1;
    end

    // Transmit dominant timeout, released when input goes recessive
    always_ff @(posedge core_clk) begin
        if (!resetn || txd_s) begin
            tx_cnt_q <= '0;
            txd_to_q <= 1'b0;
        end else if (tx_hit) begin
            txd_to_q <= 1'b1;
        end else begin
            tx_cnt_q <= tx_cnt_q + 1'b1;
        end
    end

    // Bus clamp counter, any transceiver mode
    always_ff @(posedge core_clk) begin
        if (!resetn || bus_s)
            bs_cnt_q <= '0;
        else if (!bus_hit)
            bs_cnt_q <= bs_cnt_q + 1'b1;
    end

    // Slope choices wait for the select release
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ls_pend_q <= 1'b0;
            fl_pend_q <= 1'b0;
        end else if (cfg_in.wr && sys_nrm) begin
            ls_pend_q <= cfg_in.low_slope;
            fl_pend_q <= cfg_in.flash;
        end
    end

    // Receive passes the bus only in the listening modes
    wire rx_pass = (in_norm | in_rxo) & ~uv_s;
    // A woken transceiver holds receive low until the mode moves on
    wire rx_d = (in_wake & (woken_q | wake_hit)) ? 1'b0 :
        (rx_pass ? bus_s : 1'b1);
    // Flash overrides low slope
    wire [1:0] slope_d = fl_pend_q ? `LMC_SLOPE_FLASH :
        (ls_pend_q ? `LMC_SLOPE_LOW : `LMC_SLOPE_NORMAL);
    wire fault_set = tx_hit | bus_hit;

    // Mode readback
    always_ff @(posedge core_clk) begin
        if (!resetn)
            lin_mode_field <= `LMC_MODE_OFF;
        else
            lin_mode_field <= mode_d;
    end

    // Driver stage
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            driver_enable <= 1'b0;
            bus_drive_dominant <= 1'b0;
        end else begin
            driver_enable <= drv_allow;
            bus_drive_dominant <= drv_allow & tx_gate_q & ~txd_s;
        end
    end

    // Receiver stage and receive output
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            receiver_enable <= 1'b0;
            rx_out <= 1'b1;
        end else begin
            receiver_enable <= rx_pass;
            rx_out <= rx_d;
        end
    end

    // Slope moves only on the select release, never inside a frame
    always_ff @(posedge core_clk) begin
        if (!resetn)
            slope_sel <= `LMC_SLOPE_NORMAL;
        else if (csn_rise)
            slope_sel <= slope_d;
    end

    // Sticky fault; a new timeout wins over a clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (!resetn)
            lin_fault_flag <= 1'b0;
        else if (fault_set)
            lin_fault_flag <= 1'b1;
        else if (fault_clear)
            lin_fault_flag <= 1'b0;
    end

    // Sticky wake status, same set-over-clear priority
    always_ff @(posedge core_clk) begin
        if (!resetn)
            wake_status_first <= 1'b0;
        else if (wake_hit)
            wake_status_first <= 1'b1;
        else if (wake_status_clear)
            wake_status_first <= 1'b0;
    end

    // One-cycle requests toward the system controller
    always_ff @(posedge core_clk) begin
        if (!resetn)
            sys_req <= '0;
        else begin
            sys_req.irq <= wake_hit & (sys_stp | sys_nrm);
            sys_req.to_restart <= wake_hit & (sys_slp | sys_fs);
            sys_req.wdog_enable <= wake_hit & sys_stp &
                watchdog_on_bus_wake & watchdog_disabled;
        end
    end

endmodule // lmc_mode_ctrl

`default_nettype wire

/* verif/lmc_bus_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Single-wire bus: pull-up, wired-AND, low is dominant
module lmc_bus_model (
    input wire logic bus_drive_dominant,
    input wire logic driver_enable,
    input wire logic clamp,
    output logic bus_rx_level
);
    // A disabled stage cannot pull; clamp stands in for a shorted node
    assign bus_rx_level = !((bus_drive_dominant && driver_enable) || clamp);
endmodule // lmc_bus_model
`default_nettype wire

/* verif/lmc_mode_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module lmc_mode_monitor
    import lmc_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire lmc_cfg_t cfg_in,
    input wire logic serial_select_n,
    input wire logic [2:0] sys_mode,
    input wire logic watchdog_on_bus_wake,
    input wire logic watchdog_disabled,
    input wire logic lin_transmit_input,
    input wire logic bus_rx_level,
    input wire logic bus_supply_under_v,
    input wire logic fault_clear,
    input wire logic wake_status_clear,
    input wire logic [1:0] lin_mode_field,
    input wire logic bus_drive_dominant,
    input wire logic driver_enable,
    input wire logic receiver_enable,
    input wire logic rx_out,
    input wire logic [1:0] slope_sel,
    input wire logic lin_fault_flag,
    input wire logic wake_status_first,
    input wire lmc_sys_req_t sys_req
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Pins cross two synchronisers before the output register
    sequence uv_held; bus_supply_under_v [*5]; endsequence
    sequence fs_held; (sys_mode == 3'h4) [*2]; endsequence
    reset_state_a: assert property ($rose(resetn) |-> lin_mode_field == 2'h0 && rx_out)
        else $error("bad state after reset");
    idle_driver_a: assert property (lin_mode_field != 2'h3 && $past(lin_mode_field) != 2'h3
        |-> !driver_enable) else $error("driver on outside normal");
    mode_take_a: assert property (cfg_in.wr && sys_mode == 3'h0
        |=> lin_mode_field == $past(cfg_in.mode)) else $error("mode write lost");
    mode_refuse_a: assert property (cfg_in.wr && cfg_in.mode[1] && sys_mode inside {3'h2, 3'h3}
        |=> $stable(lin_mode_field)) else $error("mode taken");
    fs_force_a: assert property (fs_held |-> lin_mode_field == 2'h1)
        else $error("fail-safe not wake mode");
    wake_only_a: assert property ($rose(wake_status_first) |-> $past(lin_mode_field) == 2'h1)
        else $error("wake outside wake mode");
    wake_hold_a: assert property (lin_mode_field == 2'h1 && $past(lin_mode_field) == 2'h1
        && $past(lin_mode_field, 2) == 2'h1 && !$past(rx_out) |-> !rx_out)
        else $error("receive released early");
    wake_irq_a: assert property (sys_req.irq
        |-> !rx_out && wake_status_first && $past(sys_mode) <= 3'h1) else $error("bad wake irq");
    wdog_wake_a: assert property (sys_req.wdog_enable
        |-> $past(sys_mode) == 3'h1 && $past(watchdog_on_bus_wake) && $past(watchdog_disabled))
        else $error("bad wdog");
    wake_req_a: assert property ($rose(wake_status_first) |->
        sys_req.irq == ($past(sys_mode) <= 3'h1)
        && sys_req.to_restart == ($past(sys_mode) inside {3'h2, 3'h4})
        && sys_req.wdog_enable == ($past(sys_mode) == 3'h1 && $past(watchdog_on_bus_wake)
        && $past(watchdog_disabled))) else $error("wrong wake request");
    uv_off_a: assert property (uv_held |-> !driver_enable && !receiver_enable)
        else $error("stages on in under-voltage");
endmodule // lmc_mode_monitor
bind lmc_mode_ctrl lmc_mode_monitor mon (.*);
`default_nettype wire

/* verif/lmc_mode_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module lmc_mode_ctrl_tb
    import lmc_pkg::*;
;
    logic core_clk = 1'b0, resetn = 1'b0, serial_select_n = 1'b1, clamp = 1'b0;
    logic watchdog_on_bus_wake = 1'b1, watchdog_disabled = 1'b1, lin_transmit_input = 1'b1;
    logic bus_supply_under_v = 1'b0, fault_clear = 1'b0, wake_status_clear = 1'b0;
    logic [2:0] sys_mode = 3'h0;
    lmc_cfg_t cfg_in = '0;
    logic bus_rx_level, bus_drive_dominant, driver_enable, receiver_enable, rx_out;
    logic lin_fault_flag, wake_status_first;
    logic [1:0] lin_mode_field, slope_sel;
    lmc_sys_req_t sys_req;
    logic [8:0] notes[$];
    int failures = 0, cmp_count = 0;
    event take;
    // Host view; a disabled stage counts as recessive
    wire [8:0] obs = {lin_mode_field, driver_enable, bus_drive_dominant & driver_enable,
        rx_out, slope_sel, lin_fault_flag, wake_status_first};
    always #25 core_clk = ~core_clk;
    lmc_mode_ctrl dut (.*);
    lmc_bus_model bus (.*);
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic note(input logic [8:0] exp);
        notes.push_back(exp);
        -> take;
    endtask
    // Scoreboard waits a moment so the outputs have settled
    always @(take) begin
        #1;
        check(obs, notes.pop_front());
    end
    task automatic close_out();
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Inputs always move 5 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #5;
    endtask
    task automatic wr(input logic [1:0] m, input logic ls, input logic fl);
        cfg_in = '{1'b1, m, ls, fl};
        step(1);
        cfg_in.wr = 1'b0;
        step(1);
    endtask
    task automatic sel_cycle();
        serial_select_n = 1'b0;
        step(2);
        serial_select_n = 1'b1;
        step(6);
    endtask
    // Dominant well past the wake filter, then released
    task automatic wake_try();
        clamp = 1'b1;
        step(3100);
        clamp = 1'b0;
        step(5);
    endtask
    task automatic clr();
        wake_status_clear = 1'b1;
        fault_clear = 1'b1;
        step(1);
        wake_status_clear = 1'b0;
        fault_clear = 1'b0;
        step(1);
    endtask
    initial begin
        repeat (99000) @(posedge core_clk);
        failures++;
        close_out();
    end
    initial begin
        void'($urandom(32'h13f6));
        step(3);
        resetn = 1'b1;
        step(3);
        note(9'h010);
        for (int s = 2; s < 4; s++) begin
            sys_mode = 3'(s);
            wr(2'h3, 1'b0, 1'b0);
            wr(2'h2, 1'b0, 1'b0);
            note(9'h010);
        end
        // Slope table: low, flash, ignored in stop, back to normal
        for (int i = 0; i < 4; i++) begin
            sys_mode = 3'(i == 2);
            wr(2'h0, i < 2, i == 1);
            if (i == 0) note(9'h010);
            sel_cycle();
            note({5'h01, i == 1 || i == 2, i == 0, 2'h0});
        end
        // Early dominant is held back until a fresh falling edge
        lin_transmit_input = 1'b0;
        wr(2'h3, 1'b0, 1'b0);
        step(250);
        note(9'h1d0);
        lin_transmit_input = 1'b1;
        step(4);
        for (int i = 0; i < 8; i++) begin
            lin_transmit_input = 1'($urandom);
            step(8);
            note({3'h7, !lin_transmit_input, lin_transmit_input, 4'h0});
        end
        lin_transmit_input = 1'b1;
        wr(2'h2, 1'b0, 1'b0);
        clamp = 1'b1;
        step(8);
        note(9'h100);
        step(40010);
        note(9'h102);
        clamp = 1'b0;
        step(4);
        clr();
        wr(2'h3, 1'b0, 1'b0);
        step(210);
        bus_supply_under_v = 1'b1;
        step(8);
        bus_supply_under_v = 1'b0;
        step(210);
        note(9'h1d0);
        lin_transmit_input = 1'b0;
        step(40010);
        note(9'h192);
        lin_transmit_input = 1'b1;
        step(8);
        note(9'h1d2);
        clr();
        wr(2'h0, 1'b0, 1'b0);
        wake_try();
        note(9'h010);
        wr(2'h1, 1'b0, 1'b0);
        wake_try();
        note(9'h081);
        clr();
        sys_mode = 3'h1;
        step(2);
        wake_try();
        note(9'h081);
        clr();
        watchdog_on_bus_wake = 1'b0;
        wr(2'h0, 1'b0, 1'b0);
        wr(2'h1, 1'b0, 1'b0);
        wake_try();
        note(9'h081);
        clr();
        sys_mode = 3'h2;
        step(2);
        wake_try();
        note(9'h081);
        clr();
        sys_mode = 3'h0;
        step(1);
        wr(2'h0, 1'b0, 1'b0);
        sys_mode = 3'h4;
        wr(2'h3, 1'b0, 1'b0);
        step(2);
        note(9'h090);
        step(2);
        close_out();
    end
endmodule // lmc_mode_ctrl_tb
`default_nettype wire
